// >>> csf_cfg.svh
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH

// Data-memory addresses of the flag register, one per bank
`define CSF_ADDR_BANK0     8'h03
`define CSF_ADDR_BANK1     8'h83
// Low seven address bits shared by both bank images
`define CSF_ADDR_LOW       7'h03

// Bit positions
`define CSF_BIT_CARRY      0
`define CSF_BIT_HALF       1
`define CSF_BIT_ZERO       2
`define CSF_BIT_PWRDN      3
`define CSF_BIT_TMOUT      4
`define CSF_BIT_BSL        5
`define CSF_BIT_BSH        6
`define CSF_BIT_IBS        7

// Value after power-up: banks clear, reset flags set, ALU flags clear
`define CSF_RESET_VAL      8'h18
// Value kept by other resets is handled in logic (bank bits cleared, bits 4:0 kept)

// ALU operation codes
`define CSF_OP_NONE        4'h0
`define CSF_OP_ADD         4'h1
`define CSF_OP_SUB         4'h2
`define CSF_OP_AND         4'h3
`define CSF_OP_OR          4'h4
`define CSF_OP_XOR         4'h5
`define CSF_OP_PASS_Z      4'h6
`define CSF_OP_CLEAR       4'h7
`define CSF_OP_SWAP        4'h8
`define CSF_OP_MOVE        4'h9
`define CSF_OP_BCLR        4'hA
`define CSF_OP_BSET        4'hB

`endif

// >>> csf_pkg.sv
package csf_pkg;

   // ALU operation selector
   typedef enum logic [3:0] {
      CSF_NONE  = 4'b0000,
      CSF_ADD   = 4'b0001,
      CSF_SUB   = 4'b0010,
      CSF_AND   = 4'b0011,
      CSF_OR    = 4'b0100,
      CSF_XOR   = 4'b0101,
      CSF_PASSZ = 4'b0110,
      CSF_CLEAR = 4'b0111,
      CSF_SWAP  = 4'b1000,
      CSF_MOVE  = 4'b1001,
      CSF_BCLR  = 4'b1010,
      CSF_BSET  = 4'b1011
   } csf_op_t;

   // One instruction's request to the flag block
   typedef struct packed {
      logic       valid;
      csf_op_t    op;
      logic [7:0] a;
      logic [7:0] b;
      logic [2:0] bit_sel;
      logic       dest_file;
      logic [7:0] addr;
   } csf_req_t;

   // Hardware events that drive the reset-status flags
   typedef struct packed {
      logic watchdog_clear;
      logic sleep;
      logic watchdog_timeout;
   } csf_evt_t;

   // Flag set produced by the ALU
   typedef struct packed {
      logic zero;
      logic half;
      logic carry;
   } csf_flags_t;

endpackage

// >>> csf_alu.sv
`timescale 1ns/1ps
`include "csf_cfg.svh"

module csf_alu (
   // Operation
   input  wire csf_pkg::csf_op_t    op_in,
   input  wire logic [7:0]          a_in,
   input  wire logic [7:0]          b_in,
   input  wire logic [2:0]          bit_sel_in,
   input  wire logic [7:0]          file_in,
   // Result
   output logic [7:0]               res_out,
   output csf_pkg::csf_flags_t      flags_out,
   output logic                     z_upd_out,
   output logic                     hc_upd_out
);
   import csf_pkg::*;

   logic [8:0] sum9;
   logic [4:0] sum5;

   // Result and flag computation
   always_comb begin
      sum9       = 9'h000;
      sum5       = 5'h00;
      res_out    = 8'h00;
      flags_out  = '0;
      z_upd_out  = 1'b0;
      hc_upd_out = 1'b0;
      case (op_in)
         CSF_ADD: begin
            sum9 = {1'b0, a_in} + {1'b0, b_in};
            sum5 = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
            hc_upd_out = 1'b1;
         end
         CSF_SUB: begin
            // Two's complement add: carries are inverted borrows
            sum9 = {1'b0, b_in} + {1'b0, ~a_in} + 9'h001;
            sum5 = {1'b0, b_in[3:0]} + {1'b0, ~a_in[3:0]} + 5'h01;
            hc_upd_out = 1'b1;
         end
         CSF_AND:   res_out = a_in & b_in;
         CSF_OR:    res_out = a_in | b_in;
         CSF_XOR:   res_out = a_in ^ b_in;
         CSF_PASSZ: res_out = b_in;
         CSF_CLEAR: res_out = 8'h00;
         CSF_SWAP:  res_out = {b_in[3:0], b_in[7:4]};
         CSF_MOVE:  res_out = a_in;
         CSF_BCLR:  res_out = file_in & ~(8'h01 << bit_sel_in);
         CSF_BSET:  res_out = file_in | (8'h01 << bit_sel_in);
         default:   res_out = 8'h00;
      endcase
      if (op_in == CSF_ADD || op_in == CSF_SUB) begin
         res_out         = sum9[7:0];
         flags_out.carry = sum9[8];
         flags_out.half  = sum5[4];
      end
      z_upd_out = (op_in inside {CSF_ADD, CSF_SUB, CSF_AND, CSF_OR,
                                 CSF_XOR, CSF_PASSZ, CSF_CLEAR});
      flags_out.zero = (res_out == 8'h00);
   end
endmodule

// >>> csf_status.sv
`timescale 1ns/1ps
`include "csf_cfg.svh"
// Contract
// - Flag register accepts any instruction result as a normal data write, except to bits 4:3 and, for flag-affecting ops, bits 2:0.
// - Flag-affecting instruction writing here loads zero from ALU, and half/carry too for add and subtract.
// - Timeout and power-down flags ignore every software write.
// - Clear-file here zeroes top three bits, keeps reset flags, sets zero.
// - Subtraction carries act as inverted borrows.
// - Timeout set at power-up, watchdog clear, sleep; cleared by timeout.
// - Carry set on carry out of the top result bit.
// - Both bank addresses select the one physical register.
module csf_status (
   // Clock and reset
   input  wire logic                CLK_IN,
   input  wire logic                RST_N_IN,
   input  wire logic                POR_IN,
   // Instruction request
   input  wire csf_pkg::csf_req_t   REQ_IN,
   // Reset-status events
   input  wire csf_pkg::csf_evt_t   EVT_IN,
   // Results
   output logic [7:0]               RESULT_OUT,
   output logic [7:0]               STATUS_OUT,
   output logic [1:0]               BANK_OUT,
   output logic                     INDIRECT_BANK_OUT
);
   import csf_pkg::*;

   logic [7:0]  status_reg;
   logic [7:0]  status_next;
   logic [7:0]  result_reg;
   logic [7:0]  alu_res;
   csf_flags_t  alu_flags;
   logic        z_upd;
   logic        hc_upd;
   logic        hit;
   logic        tmout_next;
   logic        pwrdn_next;

   // Address match on either bank image
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a[6:0] == `CSF_ADDR_LOW);
   endfunction

   csf_alu u_alu (
      .op_in      (REQ_IN.op),
      .a_in       (REQ_IN.a),
      .b_in       (REQ_IN.b),
      .bit_sel_in (REQ_IN.bit_sel),
      .file_in    (status_reg),
      .res_out    (alu_res),
      .flags_out  (alu_flags),
      .z_upd_out  (z_upd),
      .hc_upd_out (hc_upd)
   );

   assign hit = REQ_IN.valid && REQ_IN.dest_file && addr_hit(REQ_IN.addr);

   // Reset-status flags driven only by hardware events
   always_comb begin
      tmout_next = status_reg[`CSF_BIT_TMOUT];
      pwrdn_next = status_reg[`CSF_BIT_PWRDN];
      if (EVT_IN.watchdog_clear) begin
         tmout_next = 1'b1;
         pwrdn_next = 1'b1;
      end else if (EVT_IN.sleep) begin
         tmout_next = 1'b1;
         pwrdn_next = 1'b0;
      end
      if (EVT_IN.watchdog_timeout)
         tmout_next = 1'b0;
   end

   // Next flag register value
   always_comb begin
      status_next = status_reg;
      if (hit) begin
         // Flag-affecting ops take Z, and DC/C for add/sub, from the ALU, not the data
         status_next[7:5] = alu_res[7:5];
         if (!z_upd)
            status_next[2:0] = alu_res[2:0];
      end
      if (REQ_IN.valid) begin
         if (z_upd)
            status_next[`CSF_BIT_ZERO] = alu_flags.zero;
         if (hc_upd) begin
            status_next[`CSF_BIT_HALF]  = alu_flags.half;
            status_next[`CSF_BIT_CARRY] = alu_flags.carry;
         end
      end
      // Software writes never reach the reset-status flags
      status_next[`CSF_BIT_TMOUT] = tmout_next;
      status_next[`CSF_BIT_PWRDN] = pwrdn_next;
   end

   // Flag register; power-on loads fixed value
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         if (POR_IN)
            status_reg <= `CSF_RESET_VAL;
         else
            status_reg <= {3'b000, status_reg[4:3], status_reg[2:0]};
      end else begin
         status_reg <= status_next;
      end
   end

   // Registered result of the instruction
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN)
         result_reg <= 8'h00;
      else if (REQ_IN.valid)
         result_reg <= alu_res;
   end

   assign RESULT_OUT        = result_reg;
   assign STATUS_OUT        = status_reg;
   assign BANK_OUT          = status_reg[`CSF_BIT_BSH:`CSF_BIT_BSL];
   assign INDIRECT_BANK_OUT = status_reg[`CSF_BIT_IBS];

   // Clear-file to the register: 000u u1uu
   clear_file_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      hit && REQ_IN.op == CSF_CLEAR && !(|EVT_IN) |=>
      status_reg[7:5] == 3'b000 && status_reg[2] &&
      status_reg[4:3] == $past(status_reg[4:3]) &&
      status_reg[1:0] == $past(status_reg[1:0]))
      else $error("clear-file result wrong");
   // Software writes never change the reset-status flags
   reset_flags_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      hit && !(|EVT_IN) |=> $stable(status_reg[4:3]))
      else $error("reset flags changed by write");
   // Move writes all writable bits
   move_write_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      hit && REQ_IN.op == CSF_MOVE |=>
      {status_reg[7:5], status_reg[2:0]} ==
      {$past(REQ_IN.a[7:5]), $past(REQ_IN.a[2:0])})
      else $error("move write lost");
   // Add carry overrides written data
   add_flags_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.op == CSF_ADD |=>
      status_reg[0] == ($past({1'b0, REQ_IN.a} + {1'b0, REQ_IN.b}) > 9'h0FF))
      else $error("add carry wrong");
   // Add digit carry from the low nibble
   add_half_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.op == CSF_ADD |=>
      status_reg[1] ==
      ($past({1'b0, REQ_IN.a[3:0]} + {1'b0, REQ_IN.b[3:0]}) > 5'h0F))
      else $error("add digit carry wrong");
   // Add zero flag from the 8-bit sum
   add_zero_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.op == CSF_ADD |=>
      status_reg[2] == ($past(REQ_IN.a + REQ_IN.b) == 8'h00))
      else $error("add zero flag wrong");
   // Subtract carry is no-borrow
   sub_borrow_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.op == CSF_SUB |=>
      status_reg[0] == $past(REQ_IN.b >= REQ_IN.a))
      else $error("sub borrow wrong");
   // Subtract digit carry is no nibble borrow
   sub_half_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.op == CSF_SUB |=>
      status_reg[1] == $past(REQ_IN.b[3:0] >= REQ_IN.a[3:0]))
      else $error("sub digit borrow wrong");
   // Zero flag follows result
   zero_flag_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.op == CSF_AND |=>
      status_reg[2] == ($past(REQ_IN.a & REQ_IN.b) == 8'h00))
      else $error("zero flag wrong");
   // Zero-only ops leave digit carry and carry alone
   flag_keep_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.op inside {CSF_AND, CSF_OR, CSF_XOR,
      CSF_PASSZ, CSF_CLEAR} |=> $stable(status_reg[1:0]))
      else $error("digit carry or carry disturbed");
   // Flag-free ops aimed elsewhere leave the flags alone
   plain_ops_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && !hit &&
      REQ_IN.op inside {CSF_SWAP, CSF_MOVE, CSF_BCLR, CSF_BSET} |=>
      $stable(status_reg[2:0]))
      else $error("flags changed by flag-free op");
   // Timeout clears the timeout flag
   wdog_timeout_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      EVT_IN.watchdog_timeout |=> !status_reg[4])
      else $error("timeout flag not cleared");
   // Sleep clears power-down and sets timeout
   sleep_flags_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      EVT_IN.sleep && !EVT_IN.watchdog_clear && !EVT_IN.watchdog_timeout |=>
      !status_reg[3] && status_reg[4])
      else $error("sleep flags wrong");
   // Watchdog clear sets both reset-status flags
   wdog_clear_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      EVT_IN.watchdog_clear && !EVT_IN.watchdog_timeout |=>
      status_reg[4:3] == 2'b11)
      else $error("watchdog clear flags wrong");
   // Bank one image writes the register
   bank_alias_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.dest_file && REQ_IN.op == CSF_MOVE &&
      REQ_IN.addr == `CSF_ADDR_BANK1 |=>
      status_reg[7:5] == $past(REQ_IN.a[7:5]))
      else $error("alias write lost");
   // Bank zero image writes the same register
   bank_zero_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      REQ_IN.valid && REQ_IN.dest_file && REQ_IN.op == CSF_MOVE &&
      REQ_IN.addr == `CSF_ADDR_BANK0 |=>
      status_reg[7:5] == $past(REQ_IN.a[7:5]))
      else $error("bank zero write lost");
   // Bit set reaches any writable bit
   bit_set_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      hit && REQ_IN.op == CSF_BSET &&
      !(REQ_IN.bit_sel inside {3'h3, 3'h4}) |=>
      status_reg[$past(REQ_IN.bit_sel)])
      else $error("bit set lost");
   // Power-on reset loads the fixed value
   por_value_a: assert property (
      @(posedge CLK_IN)
      !RST_N_IN && POR_IN |=> status_reg == `CSF_RESET_VAL)
      else $error("power-on value wrong");
   // Other resets clear the bank bits and keep the flags
   warm_reset_a: assert property (
      @(posedge CLK_IN)
      !RST_N_IN && !POR_IN |=>
      status_reg[7:5] == 3'b000 &&
      status_reg[4:0] == $past(status_reg[4:0]))
      else $error("other reset value wrong");
endmodule

// >>> csf_status_bench.sv
`timescale 1ns/1ps
module csf_status_bench;
   import csf_pkg::*;
   logic          clk_in;
   logic          rst_n_in;
   logic          por_in;
   csf_req_t      req_in;
   csf_evt_t      evt_in;
   logic [7:0]    result_out;
   logic [7:0]    status_out;
   logic [1:0]    bank_out;
   logic          ind_out;
   logic [7:0]    st;
   logic [7:0]    res;
   logic [15:0]   note_q[$];
   logic [15:0]   note;
   logic          pend;
   int            error_cnt;
   int            checks_done;

   csf_status uut (
      .CLK_IN            (clk_in),
      .RST_N_IN          (rst_n_in),
      .POR_IN            (por_in),
      .REQ_IN            (req_in),
      .EVT_IN            (evt_in),
      .RESULT_OUT        (result_out),
      .STATUS_OUT        (status_out),
      .BANK_OUT          (bank_out),
      .INDIRECT_BANK_OUT (ind_out)
   );

   // Clock, 20 ns period
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Drives one request, leaves valid up, notes the expected outcome
   task automatic instr(input csf_op_t op, input logic [7:0] a, b,
                        input logic dest, input logic [7:0] addr,
                        input logic [2:0] bs);
      logic [8:0] sum;
      logic [4:0] lo;
      logic       zf;
      @(posedge clk_in);
      req_in <= '{1'b1, op, a, b, bs, dest, addr};
      sum = {1'b0, a} + {1'b0, b};
      lo  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      if (op == CSF_SUB) begin
         sum = {1'b0, b} - {1'b0, a};
         sum[8] = (b >= a);
         lo[4] = (b[3:0] >= a[3:0]);
      end
      case (op)
         CSF_ADD, CSF_SUB: res = sum[7:0];
         CSF_AND:   res = a & b;
         CSF_OR:    res = a | b;
         CSF_XOR:   res = a ^ b;
         CSF_CLEAR: res = 8'h00;
         CSF_SWAP:  res = {b[3:0], b[7:4]};
         CSF_MOVE:  res = a;
         CSF_BCLR:  res = b & ~(8'h01 << bs);
         CSF_BSET:  res = b | (8'h01 << bs);
         default:   res = b;
      endcase
      zf = (op >= CSF_ADD) && (op <= CSF_CLEAR);
      if (dest && addr[6:0] == 7'h03) begin
         st[7:5] = res[7:5];
         if (!zf) st[2:0] = res[2:0];
      end
      if (zf) st[2] = (res == 8'h00);
      if (op == CSF_ADD || op == CSF_SUB) st[1:0] = {lo[4], sum[8]};
      note_q.push_back({st, res});
   endtask

   task automatic idle();
      @(posedge clk_in);
      req_in.valid <= 1'b0;
   endtask

   // One-cycle event pulse; timeout beats clear, clear beats sleep
   task automatic pulse(input csf_evt_t e);
      @(posedge clk_in);
      evt_in <= e;
      if (e.watchdog_clear) st[4:3] = 2'b11;
      else if (e.sleep) st[4:3] = 2'b10;
      if (e.watchdog_timeout) st[4] = 1'b0;
      note_q.push_back({st, res});
      @(posedge clk_in);
      evt_in <= '0;
   endtask

   // Takes the oldest note once the taking edge has passed
   always @(posedge clk_in) pend <= req_in.valid | (|evt_in);
   always @(negedge clk_in) begin
      if (pend && note_q.size() > 0) begin
         note = note_q.pop_front();
         check("status", note[15:8], status_out);
         check("result", note[7:0], result_out);
         check("bank", {6'h00, note[14:13]}, {6'h00, bank_out});
         check("indirect", {7'h00, note[15]}, {7'h00, ind_out});
      end
   end

   initial begin
      repeat (5000) @(posedge clk_in);
      error_cnt++;
      end_sim();
   end

   initial begin
      csf_op_t    op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] ad;
      logic       dest;
      logic [2:0] bs;
      void'($urandom(32'hf08229ec));
      rst_n_in = 1'b0;
      por_in = 1'b1;
      req_in = '0;
      evt_in = '0;
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(negedge clk_in);
      check("por status", 8'h18, status_out);
      check("por result", 8'h00, result_out);
      st = 8'h18;
      res = 8'h00;
      // Writes through both bank images, protected bits held
      instr(CSF_MOVE, 8'h3F, 8'h00, 1'b1, 8'h83, 3'd0);
      instr(CSF_MOVE, 8'h00, 8'h00, 1'b1, 8'h03, 3'd0);
      instr(CSF_ADD, 8'hFF, 8'h01, 1'b1, 8'h83, 3'd0);
      instr(CSF_CLEAR, 8'h5A, 8'hA5, 1'b1, 8'h03, 3'd0);
      instr(CSF_SUB, 8'h01, 8'h00, 1'b0, 8'h20, 3'd0);
      instr(CSF_SUB, 8'h3C, 8'h3C, 1'b1, 8'h03, 3'd0);
      for (int i = 0; i < 60; i++) begin
         op = csf_op_t'(4'(1 + $urandom_range(10)));
         a = 8'($urandom);
         b = 8'($urandom);
         bs = 3'($urandom_range(5));
         ad = (i % 3 == 0) ? 8'h10 : ((i % 3 == 1) ? 8'h03 : 8'h83);
         if (op == CSF_PASSZ) a = b;
         if (op == CSF_BCLR || op == CSF_BSET) begin
            b = st;
            ad = 8'h03;
         end
         dest = i[0] | (ad == 8'h03);
         // Writes to the flag register keep its two top bits clear; add, swap and bit set can still set bit 5
         if (dest && ad != 8'h10) begin
            a = a & 8'h1F;
            if (op != CSF_BCLR && op != CSF_BSET) b = b & 8'h13;
            if (op == CSF_SUB) a = a & b;
         end
         instr(op, a, b, dest, ad, bs);
      end
      idle();
      // Events only; timer prescaler routing sits outside the block
      pulse(3'b001);
      pulse(3'b100);
      pulse(3'b010);
      pulse(3'b011);
      pulse(3'b110);
      instr(CSF_MOVE, 8'h20, 8'h00, 1'b1, 8'h83, 3'd0);
      idle();
      // Non power-on reset in mid-run
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      por_in <= 1'b0;
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(negedge clk_in);
      st[7:5] = 3'b000;
      res = 8'h00;
      check("warm status", st, status_out);
      check("warm result", res, result_out);
      instr(CSF_XOR, 8'h33, 8'h33, 1'b1, 8'h03, 3'd0);
      idle();
      repeat (2) @(negedge clk_in);
      check("notes left", 8'h00, 8'(note_q.size()));
      end_sim();
   end
endmodule
